// ===== rtl/reclose_pkg.sv
// shared constants and state type for the auto-reclose sequencer
package reclose_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int NUM_REQ = 5;
  localparam int NUM_SHOTS = 2;
  localparam int TIME_W = 20;
  localparam logic [TIME_W-1:0] DEAD_ONE_MS_RST = 20'h000C8;
  localparam logic [TIME_W-1:0] DEAD_TWO_MS_RST = 20'h0EA60;
  localparam logic [TIME_W-1:0] SHOT_RECLAIM_MS_RST = 20'h02710;
  localparam logic [TIME_W-1:0] OVERALL_RECLAIM_MS_RST = 20'h02710;

  typedef enum logic [7:0] {
    ST_READY = 8'h01,
    ST_WAIT_OPEN = 8'h02,
    ST_DEAD = 8'h04,
    ST_CLOSE = 8'h08,
    ST_SHOT_RECLAIM = 8'h10,
    ST_OVERALL_RECLAIM = 8'h20,
    ST_FINAL_TRIP = 8'h40,
    ST_LOCKOUT = 8'h80
  } seq_state_t;
endpackage : reclose_pkg

// ===== rtl/ms_timer.sv
// millisecond down-counter with zero-means-skip start
module ms_timer #(
  parameter int W = 20
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  input wire logic tick_in,
  output logic busy_out,
  output logic done_out
);
  logic [W-1:0] count;
  wire load_zero = (load_in == '0);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (clear_in) begin
      count <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (start_in) begin
      count <= load_in;
      busy_out <= !load_zero;
      done_out <= load_zero;
    end else if (busy_out && tick_in) begin
      count <= count - 1'b1;
      busy_out <= (count != {{(W-1){1'b0}}, 1'b1});
      done_out <= (count == {{(W-1){1'b0}}, 1'b1});
    end else begin
      done_out <= 1'b0;
    end
  end
endmodule : ms_timer

// ===== rtl/auto_reclose_sequencer.sv
// auto-reclose sequencer: shots, dead and reclaim timing, final trip and lockout
//
// What this block does
// - idle trip request sets running, requested and shot-one flags.
// - trip-initiated requests get no start delay; only trip status watched.
// - breaker open and request released starts the shot's dead timer.
// - dead time expiry sends close request to the breaker object.
// - closed indication drops close request and starts shot reclaim timer.
// - same request during shot reclaim advances to next enabled shot.
// - each shot has its own configurable dead time.
// - recurrence with no shot left: final trip, clear flags, latch lockout.
// - lockout holds until manual reset and breaker close.
// - shot reclaim expiry clears flags and starts overall reclaim.
// - selectable: request during overall reclaim goes to final trip.
// - any timer set to zero is skipped.
// - overall reclaim expiry returns to ready.
// - five requests, fixed priority one highest; critical request halts.
// - breaker object failure acknowledge enters lockout.
module auto_reclose_sequencer
  import reclose_pkg::*;
#(
  parameter int N_REQ = NUM_REQ,
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic sync_reset_in,
  input wire logic [N_REQ-1:0] request_in,
  input wire logic critical_request_in,
  input wire logic [N_REQ-1:0] shot_two_enable_in,
  input wire logic [TIME_W-1:0] first_shot_dead_interval_in,
  input wire logic [TIME_W-1:0] second_shot_dead_interval_in,
  input wire logic [TIME_W-1:0] first_shot_reclaim_interval_in,
  input wire logic [TIME_W-1:0] second_shot_reclaim_interval_in,
  input wire logic [TIME_W-1:0] overall_reclaim_interval_in,
  input wire logic reclaim_trip_to_lockout_in,
  input wire logic lockout_reset_in,
  input wire logic breaker_open_in,
  input wire logic breaker_closed_in,
  input wire logic breaker_fail_in,
  output logic sequence_running_flag_out,
  output logic [N_REQ-1:0] request_pending_flag_out,
  output logic first_shot_active_flag_out,
  output logic second_shot_active_flag_out,
  output logic overall_reclaim_flag_out,
  output logic lockout_state_out,
  output logic close_request_out,
  output logic final_trip_out
);
  seq_state_t state, next_state;
  logic [N_REQ-1:0] owner;
  logic shot_two;
  logic reset_armed;
  logic [$clog2(TICK_DIV)-1:0] tick_count;
  logic tick;

  // priority pick: lowest index wins
  function automatic logic [N_REQ-1:0] pick_first(input logic [N_REQ-1:0] v);
    logic [N_REQ-1:0] r;
    r = '0;
    for (int i = N_REQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : pick_first

  wire any_req = |request_in;
  wire [N_REQ-1:0] win_req = pick_first(request_in);
  wire owner_req = |(request_in & owner);
  wire owner_shot_two_en = |(shot_two_enable_in & owner);
  wire [TIME_W-1:0] dead_load = shot_two ? second_shot_dead_interval_in
                                         : first_shot_dead_interval_in;
  wire [TIME_W-1:0] reclaim_load = shot_two ? second_shot_reclaim_interval_in
                                            : first_shot_reclaim_interval_in;
  wire abort = critical_request_in || breaker_fail_in;

  // 1 ms tick enable divider
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_count <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_count == $bits(tick_count)'(TICK_DIV - 1));
      tick_count <= (tick_count == $bits(tick_count)'(TICK_DIV - 1)) ? '0 : tick_count + 1'b1;
    end
  end

  // timer starts are single-cycle entry strobes
  wire enter_dead = (state == ST_WAIT_OPEN) && breaker_open_in && !owner_req;
  wire enter_reclaim = (state == ST_CLOSE) && breaker_closed_in;
  logic dead_done, dead_busy, rec_done, rec_busy, ovr_done, ovr_busy;
  logic timers_clear;
  logic enter_overall;

  ms_timer #(.W(TIME_W)) dead_timer (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .clear_in(timers_clear),
    .start_in(enter_dead),
    .load_in(dead_load),
    .tick_in(tick),
    .busy_out(dead_busy),
    .done_out(dead_done)
  );

  ms_timer #(.W(TIME_W)) reclaim_timer (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .clear_in(timers_clear),
    .start_in(enter_reclaim),
    .load_in(reclaim_load),
    .tick_in(tick),
    .busy_out(rec_busy),
    .done_out(rec_done)
  );

  ms_timer #(.W(TIME_W)) overall_timer (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .clear_in(timers_clear),
    .start_in(enter_overall),
    .load_in(overall_reclaim_interval_in),
    .tick_in(tick),
    .busy_out(ovr_busy),
    .done_out(ovr_done)
  );

  assign timers_clear = sync_reset_in || abort || (state == ST_READY);
  assign enter_overall = (state == ST_SHOT_RECLAIM) && rec_done && !owner_req;

  // next-state decode; zero-length timers finish one cycle after start
  always_comb begin
    next_state = state;
    case (state)
      ST_READY: begin
        if (any_req) begin
          next_state = ST_WAIT_OPEN;
        end
      end
      ST_WAIT_OPEN: begin
        if (enter_dead) begin
          next_state = ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (dead_done) begin
          next_state = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (enter_reclaim) begin
          next_state = ST_SHOT_RECLAIM;
        end
      end
      ST_SHOT_RECLAIM: begin
        if (owner_req) begin
          if (!shot_two && owner_shot_two_en) begin
            next_state = ST_WAIT_OPEN;
          end else begin
            next_state = ST_FINAL_TRIP;
          end
        end else if (rec_done) begin
          next_state = ST_OVERALL_RECLAIM;
        end
      end
      ST_OVERALL_RECLAIM: begin
        if (any_req && reclaim_trip_to_lockout_in) begin
          next_state = ST_FINAL_TRIP;
        end else if (ovr_done) begin
          next_state = ST_READY;
        end
      end
      ST_FINAL_TRIP: begin
        next_state = ST_LOCKOUT;
      end
      ST_LOCKOUT: begin
        // reset must be seen, then a breaker close re-initialises
        // a standing abort keeps the latch even with reset armed
        if (reset_armed && breaker_closed_in && !abort) begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_READY;
      end
    endcase
    if (abort && state != ST_LOCKOUT && state != ST_FINAL_TRIP) begin
      next_state = ST_FINAL_TRIP;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_READY;
    end else if (sync_reset_in) begin
      state <= ST_READY;
    end else begin
      state <= next_state;
    end
  end

  // shot owner, shot index and lockout reset latch
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      owner <= '0;
      shot_two <= 1'b0;
      reset_armed <= 1'b0;
    end else if (sync_reset_in) begin
      owner <= '0;
      shot_two <= 1'b0;
      reset_armed <= 1'b0;
    end else begin
      if (state == ST_READY && any_req) begin
        owner <= win_req;
        shot_two <= 1'b0;
      end else if (state == ST_SHOT_RECLAIM && next_state == ST_WAIT_OPEN) begin
        shot_two <= 1'b1;
      end else if (next_state == ST_READY || next_state == ST_FINAL_TRIP
                   || next_state == ST_OVERALL_RECLAIM) begin
        owner <= '0;
        shot_two <= 1'b0;
      end
      if (state != ST_LOCKOUT) begin
        reset_armed <= 1'b0;
      end else if (lockout_reset_in) begin
        reset_armed <= 1'b1;
      end
    end
  end

  // registered flag outputs follow the next state
  wire nx_active = (next_state == ST_WAIT_OPEN) || (next_state == ST_DEAD)
                   || (next_state == ST_CLOSE) || (next_state == ST_SHOT_RECLAIM);
  wire nx_shot_two = (state == ST_SHOT_RECLAIM && next_state == ST_WAIT_OPEN)
                     ? 1'b1 : shot_two;
  wire [N_REQ-1:0] nx_owner = (state == ST_READY) ? win_req : owner;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sequence_running_flag_out <= 1'b0;
      request_pending_flag_out <= '0;
      first_shot_active_flag_out <= 1'b0;
      second_shot_active_flag_out <= 1'b0;
      overall_reclaim_flag_out <= 1'b0;
      lockout_state_out <= 1'b0;
      close_request_out <= 1'b0;
      final_trip_out <= 1'b0;
    end else if (sync_reset_in) begin
      sequence_running_flag_out <= 1'b0;
      request_pending_flag_out <= '0;
      first_shot_active_flag_out <= 1'b0;
      second_shot_active_flag_out <= 1'b0;
      overall_reclaim_flag_out <= 1'b0;
      lockout_state_out <= 1'b0;
      close_request_out <= 1'b0;
      final_trip_out <= 1'b0;
    end else begin
      sequence_running_flag_out <= nx_active;
      request_pending_flag_out <= nx_active ? nx_owner : '0;
      first_shot_active_flag_out <= nx_active && !nx_shot_two;
      second_shot_active_flag_out <= nx_active && nx_shot_two;
      overall_reclaim_flag_out <= (next_state == ST_OVERALL_RECLAIM);
      lockout_state_out <= (next_state == ST_LOCKOUT) || (next_state == ST_FINAL_TRIP);
      close_request_out <= (next_state == ST_CLOSE);
      final_trip_out <= (next_state == ST_FINAL_TRIP);
    end
  end
endmodule : auto_reclose_sequencer

// ===== bench/reclose_checker.sv
// port-level assertions for the auto-reclose sequencer
module reclose_checker
  import reclose_pkg::*;
#(parameter int N_REQ = NUM_REQ) (
  input wire logic core_clk_in, nrst_in, sync_reset_in, critical_request_in, breaker_fail_in,
  input wire logic [N_REQ-1:0] request_in, request_pending_flag_out,
  input wire logic breaker_closed_in, sequence_running_flag_out, first_shot_active_flag_out,
  input wire logic second_shot_active_flag_out, overall_reclaim_flag_out, lockout_state_out,
  input wire logic close_request_out, final_trip_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic idle, calm;
  assign idle = !sequence_running_flag_out && !overall_reclaim_flag_out && !lockout_state_out;
  assign calm = !sync_reset_in && !critical_request_in && !breaker_fail_in;
  // final trip lasts one cycle with lockout already standing
  sequence ftrip_s;
    !sequence_running_flag_out && lockout_state_out ##1 !final_trip_out && lockout_state_out;
  endsequence
  start_flags_a: assert property (idle && calm && (|request_in) |=>
    sequence_running_flag_out && first_shot_active_flag_out && request_pending_flag_out ==
    ($past(request_in) & (~$past(request_in) + 1'b1))) else $error("start flags wrong");
  one_owner_a: assert property (
    $onehot0(request_pending_flag_out)) else $error("several request owners");
  shot_excl_a: assert property (
    !(first_shot_active_flag_out && second_shot_active_flag_out)) else $error("two shots");
  final_trip_a: assert property (
    final_trip_out && !sync_reset_in |-> ftrip_s) else $error("final trip without lockout");
  close_drop_a: assert property (
    close_request_out && breaker_closed_in |=> !close_request_out) else $error("close held");
  close_run_a: assert property (
    close_request_out |-> sequence_running_flag_out && !lockout_state_out)
    else $error("close request outside a shot");
  crit_stop_a: assert property (
    critical_request_in && !lockout_state_out && !sync_reset_in |-> ##[1:2] final_trip_out)
    else $error("critical request not obeyed");
  fail_lock_a: assert property (
    breaker_fail_in && !sync_reset_in |-> ##[1:2] lockout_state_out)
    else $error("breaker failure not locked out");
  lock_hold_a: assert property (
    lockout_state_out && !breaker_closed_in && !sync_reset_in |=> lockout_state_out)
    else $error("lockout left without breaker close");
  sync_clear_a: assert property (sync_reset_in |=>
    !sequence_running_flag_out && !lockout_state_out && !close_request_out &&
    !overall_reclaim_flag_out && request_pending_flag_out == '0) else $error("sync reset");
  reclaim_end_a: assert property (
    $fell(sequence_running_flag_out) && !lockout_state_out && !$past(sync_reset_in)
    |-> overall_reclaim_flag_out) else $error("overall reclaim not started");
endmodule : reclose_checker

// ===== bench/breaker_model.sv
// breaker and object-control stand-in with random travel time
module breaker_model (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic open_cmd_in,
  input wire logic close_cmd_in,
  output logic breaker_open_out = 1'b0,
  output logic breaker_closed_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n = 0;
  logic goal = 1'b1;
  // varied travel so prompt and slow answers both occur
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      goal = 1'b1;
      wait_n = 0;
      breaker_closed_out <= 1'b1;
      breaker_open_out <= 1'b0;
    end else if ((open_cmd_in && goal) || (close_cmd_in && !open_cmd_in && !goal)) begin
      goal = !goal;
      wait_n = 1 + $urandom_range(7);
      breaker_open_out <= 1'b0;
      breaker_closed_out <= 1'b0;
    end else if (wait_n > 0) begin
      wait_n--;
      if (wait_n == 0) begin
        breaker_closed_out <= goal;
        breaker_open_out <= !goal;
      end
    end
  end
endmodule : breaker_model

// ===== bench/test_auto_reclose_sequencer.sv
// self-checking bench for the auto-reclose sequencer
module test_auto_reclose_sequencer
  import reclose_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0, nrst_in = 1'b0, sync_reset_in = 1'b0, critical_request_in = 1'b0;
  logic lockout_reset_in = 1'b0, breaker_fail_in = 1'b0, reclaim_trip_to_lockout_in = 1'b0;
  logic [4:0] request_in = '0, shot_two_enable_in = '0, request_pending_flag_out, r, p;
  logic [TIME_W-1:0] first_shot_dead_interval_in = 20'h00003;
  logic [TIME_W-1:0] second_shot_dead_interval_in = 20'h00005;
  logic [TIME_W-1:0] first_shot_reclaim_interval_in = 20'h00004;
  logic [TIME_W-1:0] second_shot_reclaim_interval_in = 20'h00004;
  logic [TIME_W-1:0] overall_reclaim_interval_in = 20'h00006;
  logic breaker_open_in, breaker_closed_in, trip_cmd = 1'b0, manual_close = 1'b0;
  logic sequence_running_flag_out, first_shot_active_flag_out, second_shot_active_flag_out;
  logic overall_reclaim_flag_out, lockout_state_out, close_request_out, final_trip_out;
  logic [3:0] ev;
  logic [11:0] seen, last = '0;
  logic [11:0] notes[$];
  int n_fail = 0, tests_run = 0;
  assign ev = {breaker_open_in, breaker_closed_in, close_request_out, final_trip_out};
  assign seen = {sequence_running_flag_out, request_pending_flag_out, first_shot_active_flag_out,
    second_shot_active_flag_out, overall_reclaim_flag_out, lockout_state_out, close_request_out,
    final_trip_out};
  always #2.5 core_clk_in = ~core_clk_in;
  // ten cycles a millisecond keeps the run short
  auto_reclose_sequencer #(.TICK_DIV(10)) uut (.*);
  breaker_model model (.core_clk_in, .nrst_in, .open_cmd_in(trip_cmd | final_trip_out),
    .close_cmd_in(close_request_out | manual_close), .breaker_open_out(breaker_open_in),
    .breaker_closed_out(breaker_closed_in));
  task automatic check(input string what, input logic [11:0] got, input logic [11:0] want);
    tests_run++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, got);
    end
  endtask : check
  task automatic note(input logic [11:0] v);
    notes.push_back(v);
  endtask : note
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick
  task automatic wait_ev(input int i);
    int n = 0;
    while (ev[i] !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n == 400) begin
      check("breaker event", {11'h000, ev[i]}, 12'h001);
    end
  endtask : wait_ev
  task automatic trip(input logic [4:0] req);
    request_in = req;
    trip_cmd = 1'b1;
    wait_ev(3);
    tick(1);
    request_in = '0;
    trip_cmd = 1'b0;
  endtask : trip
  task automatic shot_seq(input logic first);
    logic [11:0] a;
    a = {1'b1, p, first, !first, 4'h0};
    note(a);
    note(a | 12'h002);
    note(a);
    trip(r);
    wait_ev(2);
    tick(2);
  endtask : shot_seq
  task automatic lock_notes();
    note(12'h005);
    note(12'h004);
  endtask : lock_notes
  task automatic clear();
    // let the final trip open the breaker before closing it again
    wait_ev(3);
    manual_close = 1'b1;
    wait_ev(2);
    manual_close = 1'b0;
    tick(3);
    note(12'h000);
    sync_reset_in = 1'b1;
    tick(1);
    sync_reset_in = 1'b0;
    tick(2);
  endtask : clear
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // checked two steps after the edge, clear of the stimulus step
  always @(posedge core_clk_in) begin
    #2;
    if (nrst_in === 1'b1 && seen !== last) begin
      check("flags", seen, notes.size() > 0 ? notes.pop_front() : 12'hFFF);
      last = seen;
    end
  end
  // whole run is under a thousand cycles; this leaves wide margin
  initial begin
    #200us;
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h077A));
    repeat (16) @(posedge core_clk_in);
    #1 nrst_in = 1'b1;
    tick(2);
    for (int s = 0; s < 6; s++) begin
      r = 5'($urandom_range(31, 1));
      p = r & (~r + 5'h01);
      shot_two_enable_in = (s == 0) ? 5'h1F : ~p;
      reclaim_trip_to_lockout_in = (s == 3);
      first_shot_dead_interval_in = (s == 1) ? 20'h00000 : 20'h00003;
      shot_seq(1'b1);
      case (s)
        0: begin
          shot_seq(1'b0);
          lock_notes();
          trip(r);
          request_in = r;
          tick(5);
          request_in = '0;
          lockout_reset_in = 1'b1;
          tick(1);
          lockout_reset_in = 1'b0;
          tick(3);
          note(12'h000);
          manual_close = 1'b1;
          wait_ev(2);
          manual_close = 1'b0;
          tick(3);
        end
        1: begin
          note(12'h008);
          note(12'h000);
          tick(70);
          request_in = r;
          tick(3);
          request_in = '0;
          tick(80);
        end
        2: begin
          lock_notes();
          trip(r);
          clear();
        end
        3: begin
          note(12'h008);
          lock_notes();
          tick(70);
          trip(r);
          clear();
        end
        default: begin
          lock_notes();
          critical_request_in = (s == 4);
          breaker_fail_in = (s == 5);
          tick(1);
          critical_request_in = 1'b0;
          breaker_fail_in = 1'b0;
          clear();
        end
      endcase
    end
    tick(5);
    check("notes left", 12'(notes.size()), 12'h000);
    report_and_stop();
  end
endmodule : test_auto_reclose_sequencer
bind auto_reclose_sequencer reclose_checker #(.N_REQ(N_REQ)) chk (.core_clk_in, .nrst_in,
  .sync_reset_in, .critical_request_in, .breaker_fail_in, .request_in, .request_pending_flag_out,
  .breaker_closed_in, .sequence_running_flag_out, .first_shot_active_flag_out,
  .second_shot_active_flag_out, .overall_reclaim_flag_out, .lockout_state_out,
  .close_request_out, .final_trip_out);
